// File: rtl/flc_consts.vh
// Constants for the flash lock and fuse control block.
// Assumes inclusion by bare name from the rtl/ directory.
`ifndef FLC_CONSTS_VH
`define FLC_CONSTS_VH

`define FLC_BYTE_ERASED     8'hFF
`define FLC_BYTE_PROG       8'h00
`define FLC_POLL_ERASE      8'h7F
`define FLC_FUSE_COUNT      19
`define FLC_FUSE_AW         5
`define FLC_LOCK_AW         1
`define FLC_ADDR_CS0        5'h00
`define FLC_ADDR_CS1        5'h01
`define FLC_LOCK_COUNT      2
`define FLC_ADDR_STARTUP0   5'h02
`define FLC_ADDR_STARTUP1   5'h03
`define FLC_ADDR_RSTEN      5'h04
`define FLC_ADDR_BROWNOUT   5'h05
`define FLC_ADDR_DBG        5'h06
`define FLC_ADDR_PROG_EN    5'h07
`define FLC_ADDR_TRIM0      5'h08
`define FLC_ADDR_USIGP      5'h10
`define FLC_ADDR_TRIST      5'h11
`define FLC_ADDR_DBGIF      5'h12
`define FLC_FACTORY_TRIM    8'h80
`define FLC_LEVEL_1         2'h1
`define FLC_LEVEL_2         2'h2
`define FLC_LEVEL_3         2'h3
`define FLC_SPACE_CODE      2'h0
`define FLC_SPACE_USIG      2'h1
`define FLC_SPACE_FUSE      2'h2
`define FLC_SPACE_LOCK      2'h3
`define FLC_CLK_CRYSTAL     2'h0
`define FLC_CLK_RSVD        2'h1
`define FLC_CLK_EXTERNAL    2'h2
`define FLC_CLK_INTERNAL_RC 2'h3
`define FLC_STARTUP_RESET   2'h3
`define FLC_WRITE_NS        2500000
`define FLC_AUTO_NS         5000000
`define FLC_ERASE_NS        7500000
`define FLC_CLK_NS          5

`endif

// File: rtl/flc_poll_gen.v
// Busy-cycle read data shaper for complemented-MSB polling.
// Assumes the owner supplies the reference byte and busy level.
`timescale 1ns/1ps

module flc_poll_gen (
	// Clock and reset
	input  wire       mclk_i,
	input  wire       srst_i,
	// Cycle state
	input  wire       busy_i,
	input  wire       hit_i,
	input  wire [7:0] ref_i,
	input  wire [7:0] true_i,
	// Result
	output reg  [7:0] data_o
);
	always @(posedge mclk_i) begin
		if (srst_i) begin
			data_o <= 8'h00;
		end else if (busy_i && hit_i) begin
			data_o <= {~ref_i[7], ref_i[6:0]};
		end else begin
			data_o <= true_i;
		end
	end
endmodule

// File: rtl/flc_top.v
// Flash lock bits, user fuse row and programming-cycle polling.
// Assumes a command decoder on the same clock presents writes and reads
// as one-cycle strobes; serial framing lives outside this block.
//
// Operation
// - Busy read of last byte inverts MSB.
// - After cycle, same read returns stored value.
// - Chip erase polls as 7FH until done.
// - Poll reference is last byte loaded.
// - Two lock bytes, FFh clear, 00h set.
// - Only chip erase returns locks to FFh.
// - Level 2 blocks programming of every space except 00h lock writes.
// - Level 3 also blocks code reads, debug.
// - Level decoded from lock bytes 00h, 01h.
// - Nineteen fuses, one per row address.
// - Write 00h clears fuse, FFh keeps it.
// - Fuse-row erase or chip erase returns fuse to FFh.
// - Every fuse defaults to FFh.
// - Clock-source fuses select clock, POR applied.
// - Start-up fuses select wake time, POR applied.
// - Fuse 04h reset pin, applied at POR or session end with pin high.
// - Fuse 05h brown-out, 06h debug disable.
// - Fuse 07h programming enable, applied at POR or session end.
// - Fuses 08h-0Fh form RC trim byte.
// - Fuse 10H blocks user signature programming.
// - Fuse 11H port start mode; 12H FFh.
`timescale 1ns/1ps
`include "flc_consts.vh"

module flc_top #(
	parameter WRITE_CYCLES = `FLC_WRITE_NS / `FLC_CLK_NS,
	parameter AUTO_CYCLES  = `FLC_AUTO_NS / `FLC_CLK_NS,
	parameter ERASE_CYCLES = `FLC_ERASE_NS / `FLC_CLK_NS
) (
	// Clock and reset
	input  wire        mclk_i,
	input  wire        srst_i,
	// Power-on and session events
	input  wire        por_i,
	input  wire        session_end_i,
	input  wire        rst_pin_high_i,
	// Command strobes from the programming decoder
	input  wire        wr_i,
	input  wire        auto_erase_i,
	input  wire        chip_erase_i,
	input  wire        rd_i,
	input  wire [1:0]  space_i,
	input  wire [10:0] addr_i,
	input  wire [7:0]  wdata_i,
	input  wire        last_load_i,
	// Array side for code and user signature storage
	input  wire [7:0]  array_rdata_i,
	output wire        array_prog_o,
	// Read answer
	output wire [7:0]  rdata_o,
	output reg         rvalid_o,
	output reg         busy_o,
	output reg         refused_o,
	// Protection state
	output wire [1:0]  prot_level_o,
	// Applied configuration
	output reg  [1:0]  clk_source_o,
	output reg  [1:0]  startup_delay_select_o,
	output reg         reset_pin_en_o,
	output reg         brownout_detector_en_o,
	output reg         on_chip_debug_en_o,
	output reg         in_system_programming_en_o,
	output reg  [7:0]  rc_trim_o,
	output reg         usig_prog_block_o,
	output reg         ports_input_only_o,
	output wire        comparator_in_a_input_only_o,
	output wire        comparator_in_b_input_only_o,
	output wire        slave_select_quasi_o,
	output wire [7:0]  factory_trim_o
);
	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	reg [7:0]  fuse_q [0:`FLC_FUSE_COUNT-1];
	reg [7:0]  lock_q [0:1];
	reg [31:0] cnt_q;
	reg        erase_q;
	reg [7:0]  ref_q;
	reg [1:0]  ref_space_q;
	reg [10:0] ref_addr_q;
	reg [7:0]  true_d;
	reg        pend_q;
	integer    i;
	integer    j;

	localparam ST_IDLE = 1'b0;
	localparam ST_BUSY = 1'b1;
	reg        st_q;

	// A fuse or lock byte is on only while it reads FFh.
	function fon;
		input [7:0] v;
		begin
			fon = (v == `FLC_BYTE_ERASED);
		end
	endfunction

	// Fuse and lock rows are short; anything past their end is not a
	// byte of this block, for writes and reads alike.
	function addr_ok;
		input [1:0]  sp;
		input [10:0] a;
		begin
			case (sp)
			`FLC_SPACE_FUSE: addr_ok = (a < `FLC_FUSE_COUNT);
			`FLC_SPACE_LOCK: addr_ok = (a < `FLC_LOCK_COUNT);
			default:         addr_ok = 1'b1;
			endcase
		end
	endfunction

	// Only the upper lock byte programmed has no defined level; it is
	// held at level 2, which blocks programming but leaves code reads open.
	function [1:0] level_of;
		input l0;
		input l1;
		begin
			case ({l1, l0})
			2'h3:    level_of = `FLC_LEVEL_1;
			2'h0:    level_of = `FLC_LEVEL_3;
			default: level_of = `FLC_LEVEL_2;
			endcase
		end
	endfunction

	// ----------------------------------------------------------------
	// Reset pin level
	// ----------------------------------------------------------------
	// The level comes straight from a pad. The filtered copy moves only
	// once the last two stages agree, so a one-cycle glitch never qualifies a
	// session end.
	reg        pin_s1_q;
	reg        pin_s2_q;
	reg        pin_s3_q;
	reg        pin_high_q;

	always @(posedge mclk_i) begin
		if (srst_i) begin
			pin_s1_q   <= 1'b0;
			pin_s2_q   <= 1'b0;
			pin_s3_q   <= 1'b0;
			pin_high_q <= 1'b0;
		end else begin
			pin_s1_q <= rst_pin_high_i;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			if (pin_s2_q == pin_s3_q) begin
				pin_high_q <= pin_s3_q;
			end
		end
	end

	// ----------------------------------------------------------------
	// Protection level
	// ----------------------------------------------------------------
	wire lk0 = fon(lock_q[0]);
	wire lk1 = fon(lock_q[1]);
	assign prot_level_o = level_of(lk0, lk1);

	wire lvl_ge2 = (prot_level_o != `FLC_LEVEL_1);
	wire lvl3    = (prot_level_o == `FLC_LEVEL_3);

	// ----------------------------------------------------------------
	// Write acceptance
	// ----------------------------------------------------------------
	wire in_range = addr_ok(space_i, addr_i);
	wire usig_blk = (space_i == `FLC_SPACE_USIG) &&
		usig_prog_block_o;
	// Lock bytes can still be programmed further but never erased here.
	wire lock_ok = (space_i == `FLC_SPACE_LOCK) &&
		(wdata_i == `FLC_BYTE_PROG);
	wire wr_ok = wr_i && (st_q == ST_IDLE) && in_range && !usig_blk &&
		(!lvl_ge2 || lock_ok);
	wire ce_ok = chip_erase_i && (st_q == ST_IDLE);

	assign array_prog_o = wr_ok && ((space_i == `FLC_SPACE_CODE) ||
		(space_i == `FLC_SPACE_USIG));

	// ----------------------------------------------------------------
	// Cycle sequencer and nonvolatile bytes
	// ----------------------------------------------------------------
	always @(posedge mclk_i) begin
		if (srst_i) begin
			st_q        <= ST_IDLE;
			cnt_q       <= 32'h0000_0000;
			erase_q     <= 1'b0;
			ref_q       <= 8'h00;
			ref_space_q <= 2'h0;
			ref_addr_q  <= 11'h000;
			refused_o   <= 1'b0;
			for (i = 0; i < `FLC_FUSE_COUNT; i = i + 1) begin
				fuse_q[i] <= `FLC_BYTE_ERASED;
			end
			lock_q[0] <= `FLC_BYTE_ERASED;
			lock_q[1] <= `FLC_BYTE_ERASED;
		end else begin
			refused_o <= (wr_i && !wr_ok) || (chip_erase_i && !ce_ok);
			case (st_q)
			ST_IDLE: begin
				if (ce_ok) begin
					st_q    <= ST_BUSY;
					erase_q <= 1'b1;
					ref_q   <= `FLC_BYTE_ERASED;
					cnt_q   <= ERASE_CYCLES;
					lock_q[0] <= `FLC_BYTE_ERASED;
					lock_q[1] <= `FLC_BYTE_ERASED;
					for (i = 0; i < `FLC_FUSE_COUNT; i = i + 1) begin
						fuse_q[i] <= `FLC_BYTE_ERASED;
					end
				end else if (wr_ok) begin
					erase_q     <= 1'b0;
					ref_space_q <= space_i;
					ref_addr_q  <= addr_i;
					ref_q       <= wdata_i;
					if (last_load_i) begin
						st_q  <= ST_BUSY;
						cnt_q <= auto_erase_i ? AUTO_CYCLES : WRITE_CYCLES;
					end
					if (space_i == `FLC_SPACE_FUSE) begin
						if (auto_erase_i) begin
							for (i = 0; i < `FLC_FUSE_COUNT; i = i + 1) begin
								fuse_q[i] <= `FLC_BYTE_ERASED;
							end
							fuse_q[addr_i[4:0]] <= wdata_i;
						end else if (wdata_i == `FLC_BYTE_PROG) begin
							fuse_q[addr_i[4:0]] <= `FLC_BYTE_PROG;
						end
					end
					if (lock_ok) begin
						lock_q[addr_i[0]] <= `FLC_BYTE_PROG;
					end
				end
			end
			ST_BUSY: begin
				if (cnt_q <= 32'h0000_0001) begin
					st_q    <= ST_IDLE;
					erase_q <= 1'b0;
				end else begin
					cnt_q <= cnt_q - 32'h0000_0001;
				end
			end
			default: begin
				st_q <= ST_IDLE;
			end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	wire rd_code_blk = lvl3 && (space_i == `FLC_SPACE_CODE);
	wire hit = erase_q || ((space_i == ref_space_q) &&
		(addr_i == ref_addr_q));

	always @* begin
		true_d = array_rdata_i;
		if (space_i == `FLC_SPACE_FUSE) begin
			true_d = addr_ok(space_i, addr_i) ? fuse_q[addr_i[4:0]] :
				8'h00;
		end else if (space_i == `FLC_SPACE_LOCK) begin
			true_d = addr_ok(space_i, addr_i) ? lock_q[addr_i[0]] :
				8'h00;
		end else if (rd_code_blk) begin
			true_d = 8'h00;
		end
	end

	flc_poll_gen u_poll (
		.mclk_i (mclk_i),
		.srst_i (srst_i),
		.busy_i (st_q == ST_BUSY),
		.hit_i  (hit),
		.ref_i  (ref_q),
		.true_i (true_d),
		.data_o (rdata_o)
	);

	always @(posedge mclk_i) begin
		if (srst_i) begin
			rvalid_o <= 1'b0;
			busy_o   <= 1'b0;
		end else begin
			rvalid_o <= rd_i;
			busy_o   <= (st_q == ST_BUSY);
		end
	end

	// ----------------------------------------------------------------
	// Configuration outputs
	// ----------------------------------------------------------------
	// Two apply points: POR latches clock, start-up, port, reset-pin and programming-enable
	// fields, session end programming-enable and, with the pin high, reset-pin; the other fields follow the fuses every cycle.
	always @(posedge mclk_i) begin
		if (srst_i) begin
			pend_q <= 1'b0;
		end else begin
			pend_q <= por_i;
		end
	end

	always @(posedge mclk_i) begin
		if (srst_i) begin
			clk_source_o               <= `FLC_CLK_INTERNAL_RC;
			startup_delay_select_o     <= `FLC_STARTUP_RESET;
			reset_pin_en_o             <= 1'b1;
			in_system_programming_en_o <= 1'b1;
			brownout_detector_en_o     <= 1'b1;
			on_chip_debug_en_o         <= 1'b0;
			rc_trim_o                  <= 8'hFF;
			usig_prog_block_o          <= 1'b1;
			ports_input_only_o         <= 1'b1;
		end else begin
			if (pend_q) begin
				clk_source_o <= {fon(fuse_q[`FLC_ADDR_CS1]),
					fon(fuse_q[`FLC_ADDR_CS0])};
				startup_delay_select_o <=
					{fon(fuse_q[`FLC_ADDR_STARTUP1]),
					fon(fuse_q[`FLC_ADDR_STARTUP0])};
				ports_input_only_o <= fon(fuse_q[`FLC_ADDR_TRIST]);
			end
			if (pend_q || (session_end_i && pin_high_q)) begin
				reset_pin_en_o <= fon(fuse_q[`FLC_ADDR_RSTEN]);
			end
			if (pend_q || session_end_i) begin
				in_system_programming_en_o <=
					fon(fuse_q[`FLC_ADDR_PROG_EN]);
			end
			brownout_detector_en_o <=
				fon(fuse_q[`FLC_ADDR_BROWNOUT]);
			on_chip_debug_en_o <= !fon(fuse_q[`FLC_ADDR_DBG]) &&
				!lvl3;
			for (j = 0; j < 8; j = j + 1) begin
				rc_trim_o[j] <= fon(fuse_q[`FLC_ADDR_TRIM0 + j]);
			end
			usig_prog_block_o <= fon(fuse_q[`FLC_ADDR_USIGP]);
		end
	end

	assign comparator_in_a_input_only_o = 1'b1;
	assign comparator_in_b_input_only_o = 1'b1;
	assign slave_select_quasi_o         = 1'b1;
	assign factory_trim_o               = `FLC_FACTORY_TRIM;
endmodule

// File: tb/flc_top_sva.sv
// Port assertions for the lock, fuse and polling block.
// Assumes binding to flc_top; sees only its ports.
`timescale 1ns/1ps

module flc_top_sva (
	// Watched ports
	input wire       mclk_i,
	input wire       srst_i,
	input wire       wr_i,
	input wire       chip_erase_i,
	input wire       last_load_i,
	input wire       rd_i,
	input wire [1:0] space_i,
	input wire       array_prog_o,
	input wire [7:0] rdata_o,
	input wire       rvalid_o,
	input wire       busy_o,
	input wire       refused_o,
	input wire [1:0] prot_level_o,
	input wire       on_chip_debug_en_o
);
	// --------
	// Relations
	// --------
	default clocking @(posedge mclk_i); endclocking
	default disable iff (srst_i);
	chk_read_answer:
		assert property (rd_i |=> rvalid_o) else $error("read unanswered");
	chk_lock_refuse:
		assert property (wr_i && space_i != 2'h3 && prot_level_o != 2'h1
		|=> refused_o) else $error("locked write taken");
	chk_array_quiet:
		assert property (prot_level_o != 2'h1 |-> !array_prog_o)
		else $error("array written under lock");
	chk_code_hidden:
		assert property (rd_i && space_i == 2'h0 && prot_level_o == 2'h3
		|=> rdata_o == 8'h00) else $error("code read leaked");
	chk_debug_off:
		assert property (prot_level_o == 2'h3 && $past(prot_level_o) == 2'h3
		|-> !on_chip_debug_en_o) else $error("debug left on");
	chk_cycle_start:
		assert property (wr_i && last_load_i && !busy_o && space_i == 2'h0
		&& prot_level_o == 2'h1 |-> ##2 busy_o [*8])
		else $error("write cycle too short");
	chk_free_write:
		assert property (wr_i && space_i == 2'h0 && prot_level_o == 2'h1
		&& !busy_o && !$past(wr_i) && !$past(chip_erase_i) |=> !refused_o)
		else $error("unlocked write refused");
	chk_reset_state:
		assert property (disable iff (1'b0) srst_i |=> prot_level_o == 2'h1
		&& !busy_o) else $error("reset state wrong");
	cover property (rvalid_o && busy_o);
	cover property (refused_o);
	cover property (prot_level_o == 2'h3);
endmodule

bind flc_top flc_top_sva i_flc_top_sva (
	.mclk_i(mclk_i), .srst_i(srst_i), .wr_i(wr_i),
	.chip_erase_i(chip_erase_i),
	.last_load_i(last_load_i), .rd_i(rd_i), .space_i(space_i),
	.array_prog_o(array_prog_o), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
	.busy_o(busy_o), .refused_o(refused_o), .prot_level_o(prot_level_o),
	.on_chip_debug_en_o(on_chip_debug_en_o)
);

// File: tb/flc_prog_model.sv
// Programmer stand-in issuing byte requests to the lock and fuse block.
// Assumes requests change on the falling edge of the block clock.
`timescale 1ns/1ps

module flc_prog_model (
	// Clock and answers
	input  wire        mclk_i,
	input  wire        busy_i,
	input  wire        refused_i,
	input  wire [7:0]  rdata_i,
	// Requests
	output reg         wr_o = 1'b0,
	output reg         auto_erase_o = 1'b0,
	output reg         chip_erase_o = 1'b0,
	output reg         rd_o = 1'b0,
	output reg  [1:0]  space_o = 2'h0,
	output reg  [10:0] addr_o = 11'h000,
	output reg  [7:0]  wdata_o = 8'h00,
	output reg         last_load_o = 1'b0
);
	// --------
	// Request tasks
	// --------
	// Released address and data lines show the inverse so a stale value is never trusted.
	task automatic issue(input [1:0] sp, input [10:0] a, input [7:0] b,
		input ld, input ae, output rf);
		@(negedge mclk_i);
		space_o = sp;
		addr_o = a;
		wdata_o = b;
		last_load_o = ld;
		auto_erase_o = ae;
		wr_o = 1'b1;
		@(negedge mclk_i);
		rf = refused_i;
		wr_o = 1'b0;
		addr_o = ~a;
		wdata_o = ~b;
	endtask
	task automatic fetch(input [1:0] sp, input [10:0] a, output [7:0] d);
		@(negedge mclk_i);
		space_o = sp;
		addr_o = a;
		rd_o = 1'b1;
		@(negedge mclk_i);
		d = rdata_i;
		rd_o = 1'b0;
		addr_o = ~a;
	endtask
	task automatic erase_chip;
		@(negedge mclk_i);
		chip_erase_o = 1'b1;
		@(negedge mclk_i);
		chip_erase_o = 1'b0;
	endtask
	task automatic idle;
		integer n;
		@(negedge mclk_i);
		for (n = 0; n < 200 && busy_i !== 1'b0; n = n + 1)
			@(negedge mclk_i);
	endtask
	task automatic poll(input [1:0] sp, input [10:0] a, input [7:0] e);
		reg [7:0] d;
		integer n;
		d = ~e;
		for (n = 0; n < 100 && d[7] !== e[7]; n = n + 1)
			fetch(sp, a, d);
	endtask
endmodule

// File: tb/flc_top_bench.sv
// Self-checking bench for the lock, fuse and polling block.
// Assumes shortened cycle counts; one byte stands in for the whole array.
`timescale 1ns/1ps

module flc_top_bench;
	// --------
	// Harness
	// --------
	reg         mclk_i = 1'b0;
	reg         srst_i = 1'b1;
	reg         por_i = 1'b0;
	reg         session_end_i = 1'b0;
	reg         rst_pin_high_i = 1'b0;
	reg  [7:0]  array_q = 8'h00;
	wire        wr, auto_erase, chip_erase, rd, last_load, array_prog;
	wire        rvalid, busy, refused, rst_en, brown, dbg, ispe, usigb;
	wire        ca, cb, ssq, pio;
	wire [1:0]  space, lvl, cs, startup;
	wire [10:0] addr;
	wire [7:0]  wdata, rdata, trim, ftrim;
	integer     errors = 0;
	integer     comparisons = 0;
	integer     seed = 29;
	integer     k;
	reg  [31:0] rnd;
	reg  [7:0]  d, v;
	reg         rf;

	always #2.5 mclk_i = ~mclk_i;
	always @(posedge mclk_i)
		if (array_prog)
			array_q <= wdata;
	flc_top #(.WRITE_CYCLES(20), .AUTO_CYCLES(30), .ERASE_CYCLES(40))
	i_flc_top (
		.mclk_i(mclk_i), .srst_i(srst_i), .por_i(por_i),
		.session_end_i(session_end_i), .rst_pin_high_i(rst_pin_high_i),
		.wr_i(wr), .auto_erase_i(auto_erase), .chip_erase_i(chip_erase),
		.rd_i(rd), .space_i(space), .addr_i(addr), .wdata_i(wdata),
		.last_load_i(last_load), .array_rdata_i(array_q),
		.array_prog_o(array_prog), .rdata_o(rdata), .rvalid_o(rvalid),
		.busy_o(busy), .refused_o(refused), .prot_level_o(lvl),
		.clk_source_o(cs), .startup_delay_select_o(startup),
		.reset_pin_en_o(rst_en), .brownout_detector_en_o(brown),
		.on_chip_debug_en_o(dbg), .in_system_programming_en_o(ispe),
		.rc_trim_o(trim), .usig_prog_block_o(usigb),
		.ports_input_only_o(pio), .comparator_in_a_input_only_o(ca),
		.comparator_in_b_input_only_o(cb), .slave_select_quasi_o(ssq),
		.factory_trim_o(ftrim));
	flc_prog_model i_flc_prog_model (
		.mclk_i(mclk_i), .busy_i(busy), .refused_i(refused), .rdata_i(rdata),
		.wr_o(wr), .auto_erase_o(auto_erase), .chip_erase_o(chip_erase),
		.rd_o(rd), .space_o(space), .addr_o(addr), .wdata_o(wdata),
		.last_load_o(last_load));

	task chk(input [31:0] got, input [31:0] exp);
		comparisons = comparisons + 1;
		if (got !== exp) begin
			errors = errors + 1;
			$display("Error at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	function [7:0] polled(input [7:0] b);
		polled = {~b[7], b[6:0]};
	endfunction
	task w(input [1:0] sp, input [10:0] a, input [7:0] b, input ae);
		i_flc_prog_model.issue(sp, a, b, 1'b1, ae, rf);
		i_flc_prog_model.idle;
	endtask
	task wf(input [10:0] a);
		w(2'h2, a, 8'h00, 1'b0);
	endtask
	task r(input [1:0] sp, input [10:0] a);
		i_flc_prog_model.fetch(sp, a, v);
	endtask
	task complete_run;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		#50000;
		errors = errors + 1;
		complete_run;
	end
	initial begin
		repeat (2) @(negedge mclk_i);
		srst_i = 1'b0;
		chk({cs, rst_en, brown, dbg, usigb, pio, ca, cb, ssq, trim, ftrim},
			26'h3DFFF80);
		$display("test reset done");
		for (k = 0; k < 3; k = k + 1) begin
			rnd = $random(seed);
			d = (k == 0) ? 8'h80 : rnd[7:0];
			i_flc_prog_model.issue(2'h0, 11'h01F, ~d, 1'b0, 1'b0, rf);
			i_flc_prog_model.issue(2'h0, 11'h010, d, 1'b1, 1'b0, rf);
			r(2'h0, 11'h010);
			chk(v, polled(d));
			i_flc_prog_model.poll(2'h0, 11'h010, d);
			r(2'h0, 11'h010);
			chk(v, d);
		end
		$display("test polling done");
		w(2'h1, 11'h000, 8'h5A, 1'b0);
		chk(rf, 1'b1);
		wf(11'h005);
		wf(11'h006);
		wf(11'h008);
		wf(11'h010);
		w(2'h2, 11'h005, 8'hFF, 1'b0);
		chk({brown, dbg, usigb, trim}, 11'h2FE);
		w(2'h1, 11'h000, 8'h5A, 1'b0);
		chk(rf, 1'b0);
		w(2'h2, 11'h013, 8'h00, 1'b0);
		chk(rf, 1'b1);
		w(2'h2, 11'h012, 8'hFF, 1'b0);
		chk(rf, 1'b0);
		$display("test fuses done");
		wf(11'h000);
		wf(11'h002);
		wf(11'h004);
		wf(11'h007);
		wf(11'h011);
		chk({rst_en, cs, pio}, 4'hF);
		// The pin level passes a three-stage filter before it counts.
		rst_pin_high_i = 1'b1;
		repeat (5) @(negedge mclk_i);
		{session_end_i, por_i} = 2'h3;
		@(negedge mclk_i);
		{session_end_i, por_i} = 2'h0;
		repeat (3) @(negedge mclk_i);
		chk({rst_en, ispe, cs, startup, pio}, 7'h14);
		w(2'h2, 11'h005, 8'hFF, 1'b1);
		chk({brown, dbg}, 2'h2);
		wf(11'h006);
		$display("test apply done");
		w(2'h3, 11'h000, 8'h00, 1'b0);
		r(2'h3, 11'h000);
		chk({lvl, v}, 10'h200);
		w(2'h0, 11'h010, 8'h55, 1'b0);
		chk(rf, 1'b1);
		w(2'h2, 11'h005, 8'h00, 1'b0);
		chk(rf, 1'b1);
		w(2'h3, 11'h000, 8'hFF, 1'b0);
		chk(rf, 1'b1);
		w(2'h3, 11'h001, 8'h00, 1'b0);
		chk(lvl, 2'h3);
		r(2'h0, 11'h010);
		chk(v, 8'h00);
		r(2'h2, 11'h006);
		chk({v, dbg}, 9'h000);
		$display("test locks done");
		i_flc_prog_model.erase_chip;
		r(2'h1, 11'h000);
		chk(v, 8'h7F);
		i_flc_prog_model.idle;
		r(2'h2, 11'h006);
		chk({lvl, v}, 10'h1FF);
		$display("test erase done");
		complete_run;
	end
endmodule
